// ---- tzc_pkg.sv ----
package tzc_pkg;

   // register map
   localparam logic [7:0] TZC_CONFIG_ADDR  = 8'h0C;
   localparam logic [7:0] TZC_CONTROL_ADDR = 8'h0B;
   localparam logic [7:0] TZC_STATUS_ADDR  = 8'h09;

   // thermal zone configuration register
   localparam logic [7:0] TZC_CONFIG_RESET = 8'h75;
   localparam int         TZC_COOL_MSB     = 7;
   localparam int         TZC_COOL_LSB     = 6;
   localparam int         TZC_WARM_MSB     = 5;
   localparam int         TZC_WARM_LSB     = 4;
   localparam int         TZC_LOWER_MSB    = 3;
   localparam int         TZC_LOWER_LSB    = 2;
   localparam int         TZC_UPPER_MSB    = 1;
   localparam int         TZC_UPPER_LSB    = 0;

   // current select codes: 00 no charge, 01 20 %, 10 50 %, 11 100 %
   localparam logic [1:0] TZC_ISET_NONE    = 2'h0;
   localparam logic [1:0] TZC_ISET_20      = 2'h1;
   localparam logic [1:0] TZC_ISET_50      = 2'h2;
   localparam logic [1:0] TZC_ISET_FULL    = 2'h3;

   // control and status bit positions
   localparam int         TZC_REG_RST_BIT  = 7;
   localparam int         TZC_WDOG_BIT     = 7;

   // serial bus
   localparam logic [3:0] TZC_BYTE_BITS    = 4'h8;
   localparam int         TZC_SYNC_STAGES  = 2;

   // arbitrary values, no meaning beyond this design
   localparam logic [6:0] TZC_TARGET_ADDR  = 7'h2B;
   localparam logic [6:0] TZC_PART_CODE    = 7'h00;

endpackage

// ---- tzc_sync.sv ----
`timescale 1ns/1ns

module tzc_sync #(
   parameter int WIDTH = 2
) (
   // clock and reset
   input  wire logic             clk,
   input  wire logic             reset_n,
   input  wire logic             clk_en,
   // data
   input  wire logic [WIDTH-1:0] d,
   output logic      [WIDTH-1:0] q
);
   import tzc_pkg::*;

   // first stage feeds only the second; bus idles high
   genvar i;
   generate
      for (i = 0; i < WIDTH; i++) begin : g_bit
         logic [TZC_SYNC_STAGES-1:0] stage;
         always_ff @(posedge clk or negedge reset_n) begin
            if (!reset_n) begin
               stage <= '1;
            end else if (clk_en) begin
               stage <= {stage[TZC_SYNC_STAGES-2:0], d[i]};
            end
         end
         assign q[i] = stage[TZC_SYNC_STAGES-1];
      end
   endgenerate

endmodule // tzc_sync

// ---- tzc_config.sv ----
`timescale 1ns/1ns

module tzc_config (
   // clock and reset
   input  wire logic       clk,
   input  wire logic       reset_n,
   input  wire logic       clk_en,
   // two-wire bus
   input  wire logic       scl_in,
   input  wire logic       sda_in,
   output logic            sda_out,
   output logic            sda_oe,
   // charger core
   input  wire logic       watchdog_expired,
   output logic            watchdog_fault,
   output logic            safety_timer_restart,
   output logic            cool_timer_double,
   output logic            warm_timer_double,
   // zone configuration
   output logic [1:0]      cool_zone_current_select,
   output logic [1:0]      warm_zone_current_select,
   output logic [1:0]      lower_normal_threshold_select,
   output logic [1:0]      upper_normal_threshold_select
);
   import tzc_pkg::*;

   typedef enum logic [3:0] {
      TZC_IDLE, TZC_ADDR, TZC_ADDR_ACK, TZC_PTR, TZC_PTR_ACK,
      TZC_WRITE, TZC_WRITE_ACK, TZC_READ, TZC_READ_ACK
   } tzc_state_type;

   function automatic logic tzc_hit(input logic [7:0] ptr_v, input logic [7:0] addr_v);
      tzc_hit = (ptr_v == addr_v);
   endfunction

   tzc_state_type state;
   logic [1:0]    sync_q;
   logic          scl_s;
   logic          sda_s;
   logic          scl_d;
   logic          sda_d;
   logic          scl_rise;
   logic          scl_fall;
   logic          bus_start;
   logic          bus_stop;
   logic [7:0]    shift_in;
   logic [7:0]    shift_out;
   logic [3:0]    bit_cnt;
   logic          rw;
   logic [7:0]    ptr;
   logic [7:0]    rdata;
   logic          wr_stb;
   logic [7:0]    config_q;
   logic          reg_rst;
   logic          restore;

   tzc_sync #(.WIDTH(2)) u_sync (
      .clk     (clk),
      .reset_n (reset_n),
      .clk_en  (clk_en),
      .d       ({scl_in, sda_in}),
      .q       (sync_q)
   );

   assign scl_s = sync_q[1];
   assign sda_s = sync_q[0];

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         scl_d <= 1'b1;
         sda_d <= 1'b1;
      end else if (clk_en) begin
         scl_d <= scl_s;
         sda_d <= sda_s;
      end
   end

   assign scl_rise  = scl_s & ~scl_d;
   assign scl_fall  = ~scl_s & scl_d;
   assign bus_start = scl_s & scl_d & sda_d & ~sda_s;
   assign bus_stop  = scl_s & scl_d & ~sda_d & sda_s;

   // open drain: only ever pull low
   assign sda_out = 1'b0;

   assign wr_stb  = clk_en && (state == TZC_WRITE) && scl_fall && (bit_cnt == TZC_BYTE_BITS);
   assign restore = reg_rst | watchdog_expired;

   always_comb begin
      rdata = 8'h00;
      if (tzc_hit(ptr, TZC_CONFIG_ADDR)) begin
         rdata = config_q;
      end else if (tzc_hit(ptr, TZC_CONTROL_ADDR)) begin
         rdata = {reg_rst, TZC_PART_CODE};
      end else if (tzc_hit(ptr, TZC_STATUS_ADDR)) begin
         rdata = {watchdog_fault, 7'h00};
      end
   end

   // bus target: address, pointer, then data bytes with auto-increment
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         state     <= TZC_IDLE;
         shift_in  <= 8'h00;
         shift_out <= 8'h00;
         bit_cnt   <= 4'h0;
         rw        <= 1'b0;
         ptr       <= 8'h00;
         sda_oe    <= 1'b0;
      end else if (clk_en) begin
         if (bus_start) begin
            state   <= TZC_ADDR;
            bit_cnt <= 4'h0;
            sda_oe  <= 1'b0;
         end else if (bus_stop) begin
            state  <= TZC_IDLE;
            sda_oe <= 1'b0;
         end else begin
            case (state)
               TZC_IDLE: begin
                  sda_oe <= 1'b0;
               end
               TZC_ADDR, TZC_PTR, TZC_WRITE: begin
                  if (scl_rise) begin
                     shift_in <= {shift_in[6:0], sda_s};
                     bit_cnt  <= bit_cnt + 4'h1;
                  end else if (scl_fall && bit_cnt == TZC_BYTE_BITS) begin
                     bit_cnt <= 4'h0;
                     if (state == TZC_ADDR) begin
                        if (shift_in[7:1] == TZC_TARGET_ADDR) begin
                           sda_oe <= 1'b1;
                           rw     <= shift_in[0];
                           state  <= TZC_ADDR_ACK;
                        end else begin
                           state <= TZC_IDLE;
                        end
                     end else if (state == TZC_PTR) begin
                        sda_oe <= 1'b1;
                        ptr    <= shift_in;
                        state  <= TZC_PTR_ACK;
                     end else begin
                        sda_oe <= 1'b1;
                        ptr    <= ptr + 8'h01;
                        state  <= TZC_WRITE_ACK;
                     end
                  end
               end
               TZC_ADDR_ACK, TZC_READ_ACK: begin
                  if (scl_rise && state == TZC_READ_ACK && sda_s) begin
                     state <= TZC_IDLE;
                  end else if (scl_fall && (rw || state == TZC_READ_ACK)) begin
                     shift_out <= rdata;
                     sda_oe    <= ~rdata[7];
                     ptr       <= ptr + 8'h01;
                     state     <= TZC_READ;
                  end else if (scl_fall) begin
                     sda_oe <= 1'b0;
                     state  <= TZC_PTR;
                  end
               end
               TZC_PTR_ACK, TZC_WRITE_ACK: begin
                  if (scl_fall) begin
                     sda_oe <= 1'b0;
                     state  <= TZC_WRITE;
                  end
               end
               TZC_READ: begin
                  if (scl_rise) begin
                     bit_cnt <= bit_cnt + 4'h1;
                  end else if (scl_fall && bit_cnt == TZC_BYTE_BITS) begin
                     bit_cnt <= 4'h0;
                     sda_oe  <= 1'b0;
                     state   <= TZC_READ_ACK;
                  end else if (scl_fall) begin
                     shift_out <= {shift_out[6:0], 1'b0};
                     sda_oe    <= ~shift_out[6];
                  end
               end
               default: begin
                  state  <= TZC_IDLE;
                  sda_oe <= 1'b0;
               end
            endcase
         end
      end
   end

   // restore beats a simultaneous write; whole byte incl. bits 3 and 1
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         config_q <= TZC_CONFIG_RESET;
      end else if (clk_en) begin
         if (restore) begin
            config_q <= TZC_CONFIG_RESET;
         end else if (wr_stb && tzc_hit(ptr, TZC_CONFIG_ADDR)) begin
            config_q <= shift_in;
         end
      end
   end

   assign cool_zone_current_select      = config_q[TZC_COOL_MSB:TZC_COOL_LSB];
   assign warm_zone_current_select      = config_q[TZC_WARM_MSB:TZC_WARM_LSB];
   assign lower_normal_threshold_select = config_q[TZC_LOWER_MSB:TZC_LOWER_LSB];
   assign upper_normal_threshold_select = config_q[TZC_UPPER_MSB:TZC_UPPER_LSB];

   // reset bit lives one cycle: the restore cycle
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         reg_rst              <= 1'b0;
         safety_timer_restart <= 1'b0;
      end else if (clk_en) begin
         safety_timer_restart <= reg_rst;
         if (wr_stb && tzc_hit(ptr, TZC_CONTROL_ADDR)) begin
            reg_rst <= shift_in[TZC_REG_RST_BIT];
         end else begin
            reg_rst <= 1'b0;
         end
      end
   end

   // expiry wins over the clear of any host write
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         watchdog_fault <= 1'b0;
      end else if (clk_en) begin
         if (watchdog_expired) begin
            watchdog_fault <= 1'b1;
         end else if (wr_stb) begin
            watchdog_fault <= 1'b0;
         end
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         cool_timer_double <= 1'b1;
         warm_timer_double <= 1'b0;
      end else if (clk_en) begin
         cool_timer_double <= (config_q[TZC_COOL_MSB:TZC_COOL_LSB] != TZC_ISET_FULL);
         warm_timer_double <= (config_q[TZC_WARM_MSB:TZC_WARM_LSB] != TZC_ISET_FULL);
      end
   end

   logic cfg_wr_clean;
   assign cfg_wr_clean = wr_stb && tzc_hit(ptr, TZC_CONFIG_ADDR) && !restore;

   AST_CFG_WRITE: assert property (@(posedge clk) disable iff (!reset_n)
      cfg_wr_clean |=> (config_q == $past(shift_in)))
      else $error("config write not stored");
   AST_COOL_FIELD: assert property (@(posedge clk) disable iff (!reset_n)
      cfg_wr_clean |=> (cool_zone_current_select == $past(shift_in[7:6])))
      else $error("cool select wrong");
   AST_WARM_FIELD: assert property (@(posedge clk) disable iff (!reset_n)
      cfg_wr_clean |=> (warm_zone_current_select == $past(shift_in[5:4])))
      else $error("warm select wrong");
   AST_NO_DOUBLE: assert property (@(posedge clk) disable iff (!reset_n)
      (clk_en && cool_zone_current_select == TZC_ISET_FULL) |=> !cool_timer_double)
      else $error("cool timer doubled at full current");
   AST_NO_DOUBLE_WARM: assert property (@(posedge clk) disable iff (!reset_n)
      (clk_en && warm_zone_current_select == TZC_ISET_FULL) |=> !warm_timer_double)
      else $error("warm timer doubled at full current");
   AST_LOWER_FIELD: assert property (@(posedge clk) disable iff (!reset_n)
      cfg_wr_clean |=> (lower_normal_threshold_select == $past(shift_in[3:2])))
      else $error("lower threshold wrong");
   AST_UPPER_FIELD: assert property (@(posedge clk) disable iff (!reset_n)
      cfg_wr_clean |=> (upper_normal_threshold_select == $past(shift_in[1:0])))
      else $error("upper threshold wrong");
   AST_REG_RST: assert property (@(posedge clk) disable iff (!reset_n)
      (clk_en && reg_rst && !wr_stb) |=> (!reg_rst && safety_timer_restart
         && config_q == TZC_CONFIG_RESET))
      else $error("register reset incomplete");
   AST_WDOG: assert property (@(posedge clk) disable iff (!reset_n)
      (clk_en && watchdog_expired) |=> (watchdog_fault && config_q == TZC_CONFIG_RESET))
      else $error("watchdog expiry not handled");
   AST_RST_BITS31: assert property (@(posedge clk) disable iff (!reset_n)
      (clk_en && reg_rst) |=> (config_q[3] == TZC_CONFIG_RESET[3]
         && config_q[1] == TZC_CONFIG_RESET[1]))
      else $error("bits 3 and 1 not restored");

   COV_CFG_WRITE: cover property (@(posedge clk) disable iff (!reset_n) cfg_wr_clean);
   COV_REG_RST: cover property (@(posedge clk) disable iff (!reset_n) reg_rst ##1 safety_timer_restart);
   COV_WDOG: cover property (@(posedge clk) disable iff (!reset_n) watchdog_expired);
   COV_READ: cover property (@(posedge clk) disable iff (!reset_n) state == TZC_READ_ACK);

endmodule // tzc_config

// ---- tzc_host.sv ----
`timescale 1ns/1ns

module tzc_host (
   // clock
   input  wire logic clk,
   // bus pins
   input  wire logic sda_line,
   output logic      scl,
   output logic      sda_low
);
   import tzc_pkg::*;

   // bus phase well above the 3 clk pin lag of the device
   localparam int HALF = 12;

   initial begin
      scl     = 1'b1;
      sda_low = 1'b0;
   end

   task automatic wait_clk(input int n);
      repeat (n) @(negedge clk);
   endtask

   // doubles as repeated start, scl is low on entry then
   task automatic start();
      sda_low = 1'b0;
      wait_clk(HALF);
      scl = 1'b1;
      wait_clk(HALF);
      sda_low = 1'b1;
      wait_clk(HALF);
      scl = 1'b0;
   endtask

   task automatic stop();
      wait_clk(3);
      sda_low = 1'b1;
      wait_clk(HALF);
      scl = 1'b1;
      wait_clk(HALF);
      sda_low = 1'b0;
      wait_clk(HALF);
   endtask

   // data held 3 clk past scl fall so no false start or stop is seen
   task automatic xfer(input logic b, output logic r);
      wait_clk(3);
      sda_low = ~b;
      wait_clk(HALF);
      scl = 1'b1;
      wait_clk(HALF);
      r   = sda_line;
      scl = 1'b0;
   endtask

   task automatic send(input logic [7:0] d, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--) xfer(d[i], r);
      xfer(1'b1, r);
      ack = ~r;
   endtask

   task automatic recv(input logic last, output logic [7:0] d);
      logic r;
      for (int i = 7; i >= 0; i--) xfer(1'b1, d[i]);
      xfer(last, r);
   endtask

   task automatic write_reg(input logic [7:0] ptr, input logic [7:0] d, output logic [2:0] acks);
      start();
      send({TZC_TARGET_ADDR, 1'b0}, acks[2]);
      send(ptr, acks[1]);
      send(d, acks[0]);
      stop();
   endtask

   task automatic read_reg(input logic [7:0] ptr, output logic [7:0] d);
      logic a;
      start();
      send({TZC_TARGET_ADDR, 1'b0}, a);
      send(ptr, a);
      start();
      send({TZC_TARGET_ADDR, 1'b1}, a);
      recv(1'b1, d);
      stop();
   endtask

   // two data bytes in one frame, device auto-increments the pointer
   task automatic write_pair(input logic [7:0] ptr, input logic [7:0] d0, input logic [7:0] d1);
      logic a;
      start();
      send({TZC_TARGET_ADDR, 1'b0}, a);
      send(ptr, a);
      send(d0, a);
      send(d1, a);
      stop();
   endtask

   // master ack after the first byte asks for the next one
   task automatic read_pair(input logic [7:0] ptr, output logic [7:0] d0, output logic [7:0] d1);
      logic a;
      start();
      send({TZC_TARGET_ADDR, 1'b0}, a);
      send(ptr, a);
      start();
      send({TZC_TARGET_ADDR, 1'b1}, a);
      recv(1'b0, d0);
      recv(1'b1, d1);
      stop();
   endtask

endmodule // tzc_host

// ---- test_thermal_zone_charge_config.sv ----
`timescale 1ns/1ns
`define CHK(nm, e, g) \
   begin \
      samples_checked++; \
      if ((g) !== (e)) begin \
         err_total++; \
         $display("mismatch %s expected %h seen %h", nm, e, g); \
      end \
   end

module test_thermal_zone_charge_config;
   import tzc_pkg::*;

   logic       clk;
   logic       reset_n;
   logic       clk_en;
   logic       watchdog_expired;
   logic       scl;
   logic       sda_low;
   logic       sda_line;
   logic       sda_out;
   logic       sda_oe;
   logic       watchdog_fault;
   logic       safety_timer_restart;
   logic       cool_timer_double;
   logic       warm_timer_double;
   logic [1:0] cool_sel;
   logic [1:0] warm_sel;
   logic [1:0] lower_sel;
   logic [1:0] upper_sel;
   int         err_total;
   int         samples_checked;
   int         restarts;
   logic [2:0] acks;
   logic [7:0] rd;
   logic [7:0] rd2;
   // every code of every field appears once
   logic [7:0] cfg_table [4] = '{8'h1B, 8'h6C, 8'hB1, 8'hC6};

   // open drain line with pull-up
   assign sda_line = ~(sda_low | (sda_oe & ~sda_out));

   tzc_config tzc_config_i (
      .clk                           (clk),
      .reset_n                       (reset_n),
      .clk_en                        (clk_en),
      .scl_in                        (scl),
      .sda_in                        (sda_line),
      .sda_out                       (sda_out),
      .sda_oe                        (sda_oe),
      .watchdog_expired              (watchdog_expired),
      .watchdog_fault                (watchdog_fault),
      .safety_timer_restart          (safety_timer_restart),
      .cool_timer_double             (cool_timer_double),
      .warm_timer_double             (warm_timer_double),
      .cool_zone_current_select      (cool_sel),
      .warm_zone_current_select      (warm_sel),
      .lower_normal_threshold_select (lower_sel),
      .upper_normal_threshold_select (upper_sel)
   );

   tzc_host tzc_host_i (
      .clk      (clk),
      .sda_line (sda_line),
      .scl      (scl),
      .sda_low  (sda_low)
   );

   initial clk = 1'b0;
   always #2 clk = ~clk;

   always @(posedge clk) begin
      if (safety_timer_restart === 1'b1) restarts++;
   end

   task automatic end_sim();
      $display("checks %0d mismatches %0d", samples_checked, err_total);
      if (err_total == 0 && samples_checked > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   task automatic check_cfg(input logic [7:0] v);
      `CHK("cool", v[7:6], cool_sel)
      `CHK("warm", v[5:4], warm_sel)
      `CHK("lower", v[3:2], lower_sel)
      `CHK("upper", v[1:0], upper_sel)
      `CHK("cool_double", v[7:6] != 2'h3, cool_timer_double)
      `CHK("warm_double", v[5:4] != 2'h3, warm_timer_double)
      tzc_host_i.read_reg(TZC_CONFIG_ADDR, rd);
      `CHK("readback", v, rd)
   endtask

   initial begin
      reset_n          = 1'b0;
      clk_en           = 1'b1;
      watchdog_expired = 1'b0;
      err_total        = 0;
      samples_checked  = 0;
      restarts         = 0;
      repeat (10) @(negedge clk);
      reset_n = 1'b1;
      @(negedge clk);
      check_cfg(TZC_CONFIG_RESET);
      foreach (cfg_table[i]) begin
         tzc_host_i.write_reg(TZC_CONFIG_ADDR, cfg_table[i], acks);
         `CHK("acks", 3'h7, acks)
         check_cfg(cfg_table[i]);
      end
      // bits 3 and 1 set, where only the watchdog is printed as their reset source
      tzc_host_i.write_reg(TZC_CONFIG_ADDR, 8'h8A, acks);
      restarts = 0;
      tzc_host_i.write_reg(TZC_CONTROL_ADDR, 8'h80, acks);
      `CHK("restarts", 1, restarts)
      check_cfg(TZC_CONFIG_RESET);
      tzc_host_i.read_reg(TZC_CONTROL_ADDR, rd);
      `CHK("reg_rst", {1'b0, TZC_PART_CODE}, rd)
      // frozen block must ignore an expiry pulse
      clk_en           = 1'b0;
      watchdog_expired = 1'b1;
      @(negedge clk);
      watchdog_expired = 1'b0;
      @(negedge clk);
      clk_en = 1'b1;
      @(negedge clk);
      `CHK("frozen_fault", 1'b0, watchdog_fault)
      tzc_host_i.write_reg(TZC_CONFIG_ADDR, 8'h0A, acks);
      watchdog_expired = 1'b1;
      @(negedge clk);
      watchdog_expired = 1'b0;
      @(negedge clk);
      `CHK("wd_fault", 1'b1, watchdog_fault)
      check_cfg(TZC_CONFIG_RESET);
      tzc_host_i.read_reg(TZC_STATUS_ADDR, rd);
      `CHK("wd_status", 1'b1, rd[TZC_WDOG_BIT])
      tzc_host_i.read_reg(8'h20, rd);
      `CHK("unmapped", 8'h00, rd)
      // pointer walks from 0x0B into 0x0C on write and on read
      tzc_host_i.write_pair(TZC_CONTROL_ADDR, 8'h00, 8'h9C);
      `CHK("wr_fault", 1'b0, watchdog_fault)
      check_cfg(8'h9C);
      tzc_host_i.read_pair(TZC_CONTROL_ADDR, rd, rd2);
      `CHK("burst0", {1'b0, TZC_PART_CODE}, rd)
      `CHK("burst1", 8'h9C, rd2)
      tzc_host_i.start();
      tzc_host_i.send({~TZC_TARGET_ADDR, 1'b0}, acks[0]);
      tzc_host_i.stop();
      `CHK("foreign", 1'b0, acks[0])
      end_sim();
   end

   // run needs about 20000 cycles
   initial begin
      repeat (60000) @(posedge clk);
      err_total++;
      end_sim();
   end

endmodule // test_thermal_zone_charge_config
